/* File: rtl/sysctl_pkg.sv */
/*
 * Shared constants for the system control block.
 * Assumes an 8-bit register port and a 50 MHz bus clock.
 */
package sysctl_pkg;
    // ********************
    // Register offsets
    // ********************
    localparam logic [3:0] OFS_CLKOUT = 4'h0;
    localparam logic [3:0] OFS_PNHIGH = 4'h1;
    localparam logic [3:0] OFS_PNLOW = 4'h2;
    localparam logic [3:0] OFS_WAKEUP = 4'h3;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;

    // ********************
    // Field positions
    // ********************
    localparam int BIT_PIN_EN = 4;
    localparam int BIT_FLAG = 7;
    localparam int BIT_ACK = 6;
    localparam int BIT_SRC = 5;
    localparam int BIT_IE = 4;
    localparam int BIT_EV_TIMEOUT = 0;

    // ********************
    // Reset values
    // ********************
    localparam logic [7:0] RST_CLKOUT = 8'h00;
    localparam logic [7:0] RST_WAKEUP = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // ********************
    // Timing
    // ********************
    // Bus clock and slow oscillator rates in Hz.
    localparam int BUS_CLK_HZ = 50_000_000;
    localparam int SLOW_OSC_HZ = 1_000;
    // Nominal wakeup periods in ms, codes 1 to 7.
    localparam int PER_MS_1 = 8;
    localparam int PER_MS_2 = 32;
    localparam int PER_MS_3 = 64;
    localparam int PER_MS_4 = 128;
    localparam int PER_MS_5 = 256;
    localparam int PER_MS_6 = 512;
    localparam int PER_MS_7 = 1024;
    // Slow oscillator ticks per millisecond.
    localparam int TICKS_PER_MS = SLOW_OSC_HZ / 1_000;
    // Crystal divide ratios, codes 1 to 7.
    localparam int XDIV_1 = 256;
    localparam int XDIV_2 = 1024;
    localparam int XDIV_3 = 2048;
    localparam int XDIV_4 = 4096;
    localparam int XDIV_5 = 8192;
    localparam int XDIV_6 = 16384;
    localparam int XDIV_7 = 32768;
endpackage

/* File: rtl/sysctl_regs.sv */
/*
 * System control registers: divided clock
 * output, part number and periodic wakeup timer.
 * Assumes one bus clock, an 8-bit register port
 * and slow/crystal clocks arriving as pins.
 */
// The register addresses and the strobed register port were chosen for this implementation.
// Operation
// - Enable bit gates clock onto pin.
// - Output frequency is bus over twice select.
// - Zero select with enable drives pin low.
// - Upper high-id bits reserved, writes ignored.
// - Fixed 12-bit part number, read only.
// - Timeout flag set on wakeup timeout.
// - Writing one to acknowledge clears flag.
// - Source bit picks slow or crystal.
// - Enable bit gates the wakeup interrupt.
// - Zero delay select stops the timer.
// - Slow source periods 8 ms to 1.024 s.
// - Crystal source divides 256 to 32768.
// - Slow oscillator independent of other clocks.
// - Unused control bits read as zero.
`timescale 1ns/1ps

module sysctl_regs
#(
    // Part number; the value is arbitrary.
    parameter logic [11:0] PART_ID = 12'h0_5A3,
    // Width of the wakeup period counter.
    parameter int CNT_W = 16
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic slow_osc_i,
    input wire logic xtal_clk_i,
    output logic port_c_bit_two_pin_o,
    output logic clock_out_pin_enable_o,
    output logic wakeup_irq_o,
    output logic sys_irq_o
);
    import sysctl_pkg::*;

    // ********************
    // Elaboration checks
    // ********************
    // The counter must hold the largest ratio.
    if (CNT_W < 16)
    begin : g_bad_cnt
        $error("CNT_W too small for 32768");
    end

    // ********************
    // State
    // ********************
    typedef struct packed {
        logic [7:0] rdata;      // Read data, one cycle late.
        logic pin_en;           // Clock output enable.
        logic [2:0] div_sel;    // Clock divide select.
        logic [2:0] div_cnt;    // Half period counter.
        logic div_q;            // Divided clock phase.
        logic pin_q;            // Registered pin level.
        logic pin_en_q;         // Registered pin ownership.
        logic flag;             // Wakeup timeout flag.
        logic src;              // Wakeup clock source.
        logic ie;               // Wakeup interrupt enable.
        logic [2:0] dly;        // Wakeup delay select.
        logic [CNT_W-1:0] cnt;  // Wakeup period counter.
        logic [7:0] ev_stat;    // Sticky event status.
        logic [7:0] ev_mask;    // Event mask.
        logic wirq;             // Wakeup interrupt level.
        logic sirq;             // Masked event interrupt.
        logic slow_m;           // Slow osc first stage.
        logic slow_s;           // Slow osc second stage.
        logic slow_p;           // Slow osc previous level.
        logic xtal_m;           // Crystal first stage.
        logic xtal_s;           // Crystal second stage.
        logic xtal_p;           // Crystal previous level.
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // ********************
    // Helpers
    // ********************
    // Terminal count of one wakeup period.
    // Slow source counts ms ticks, crystal
    // source counts crystal edges.
    function automatic logic [CNT_W-1:0] term_f
    (
        input logic src,
        input logic [2:0] sel
    );
        int t;
        t = 1;
        if (src)
        begin
            case (sel)
                3'h1: t = XDIV_1;
                3'h2: t = XDIV_2;
                3'h3: t = XDIV_3;
                3'h4: t = XDIV_4;
                3'h5: t = XDIV_5;
                3'h6: t = XDIV_6;
                3'h7: t = XDIV_7;
                default: t = 1;
            endcase
        end
        else
        begin
            case (sel)
                3'h1: t = PER_MS_1 * TICKS_PER_MS;
                3'h2: t = PER_MS_2 * TICKS_PER_MS;
                3'h3: t = PER_MS_3 * TICKS_PER_MS;
                3'h4: t = PER_MS_4 * TICKS_PER_MS;
                3'h5: t = PER_MS_5 * TICKS_PER_MS;
                3'h6: t = PER_MS_6 * TICKS_PER_MS;
                3'h7: t = PER_MS_7 * TICKS_PER_MS;
                default: t = 1;
            endcase
        end
        return CNT_W'(t - 1);
    endfunction

    // Wakeup control register as read back.
    function automatic logic [7:0] wake_rd_f
    (
        input state_t s
    );
        logic [7:0] v;
        v = 8'h00;
        v[BIT_FLAG] = s.flag;
        v[BIT_SRC] = s.src;
        v[BIT_IE] = s.ie;
        v[2:0] = s.dly;
        return v;
    endfunction

    // ********************
    // Next state
    // ********************
    // All state advances here; a low clock
    // enable holds every bit as it stands.
    always_comb
    begin
        logic slow_edge;
        logic xtal_edge;
        logic tick;
        logic timeout;
        logic wr_wake;
        logic ack;
        state_nxt = state_r;
        slow_edge = 1'b0;
        xtal_edge = 1'b0;
        tick = 1'b0;
        timeout = 1'b0;
        wr_wake = 1'b0;
        ack = 1'b0;

        if (ce_i)
        begin
            // slow oscillator is its own
            // pin; synchronised, edge detected on
            // the second stage only.
            state_nxt.slow_m = slow_osc_i;
            state_nxt.slow_s = state_r.slow_m;
            state_nxt.slow_p = state_r.slow_s;
            slow_edge = state_r.slow_s & ~state_r.slow_p;
            state_nxt.xtal_m = xtal_clk_i;
            state_nxt.xtal_s = state_r.xtal_m;
            state_nxt.xtal_p = state_r.xtal_s;
            xtal_edge = state_r.xtal_s & ~state_r.xtal_p;
            // The crystal is sampled, so it must
            // stay below a quarter of the bus rate.

            // ****************
            // Register writes
            // ****************
            wr_wake = wr_i && (addr_i == OFS_WAKEUP);
            if (wr_i)
            begin
                case (addr_i)
                    OFS_CLKOUT:
                    begin
                        state_nxt.pin_en = wr_data_i[BIT_PIN_EN];
                        state_nxt.div_sel = wr_data_i[2:0];
                    end
                    OFS_WAKEUP:
                    begin
                        state_nxt.src = wr_data_i[BIT_SRC];
                        state_nxt.ie = wr_data_i[BIT_IE];
                        state_nxt.dly = wr_data_i[2:0];
                        ack = wr_data_i[BIT_ACK];
                    end
                    OFS_IRQ_STAT:
                    begin
                        // Write one to clear.
                        state_nxt.ev_stat = state_r.ev_stat & ~wr_data_i;
                    end
                    OFS_IRQ_MASK:
                    begin
                        state_nxt.ev_mask = wr_data_i;
                    end
                    default:
                    begin
                        state_nxt.ev_mask = state_r.ev_mask;
                    end
                endcase
            end

            // ****************
            // Register reads
            // ****************
            // Data stands only in the cycle after
            // the strobe; otherwise it reads zero.
            state_nxt.rdata = 8'h00;
            if (rd_i)
            begin
                case (addr_i)
                    OFS_CLKOUT:
                    begin
                        state_nxt.rdata[BIT_PIN_EN] = state_r.pin_en;
                        state_nxt.rdata[2:0] = state_r.div_sel;
                    end
                    OFS_PNHIGH:
                    begin
                        state_nxt.rdata = {4'h0, PART_ID[11:8]};
                    end
                    OFS_PNLOW:
                    begin
                        state_nxt.rdata = PART_ID[7:0];
                    end
                    OFS_WAKEUP:
                    begin
                        state_nxt.rdata = wake_rd_f(state_r);
                    end
                    OFS_IRQ_STAT:
                    begin
                        state_nxt.rdata = state_r.ev_stat;
                    end
                    OFS_IRQ_MASK:
                    begin
                        state_nxt.rdata = state_r.ev_mask;
                    end
                    // Unmapped offsets read zero.
                    default:
                    begin
                        state_nxt.rdata = 8'h00;
                    end
                endcase
            end

            // ****************
            // Clock output
            // ****************
            // toggle every select cycles
            // so one period is twice the select.
            if (state_r.div_sel == 3'h0)
            begin
                state_nxt.div_cnt = 3'h0;
                state_nxt.div_q = 1'b0;
            end
            else if (state_r.div_cnt >= state_r.div_sel - 3'h1)
            begin
                // A shrunk select also lands here,
                // so the counter never runs away.
                state_nxt.div_cnt = 3'h0;
                state_nxt.div_q = ~state_r.div_q;
            end
            else
            begin
                state_nxt.div_cnt = state_r.div_cnt + 3'h1;
            end
            state_nxt.pin_en_q = state_r.pin_en;
            // zero select holds the pin low.
            if (state_r.pin_en && state_r.div_sel != 3'h0)
            begin
                state_nxt.pin_q = state_r.div_q;
            end
            else
            begin
                state_nxt.pin_q = 1'b0;
            end

            // ****************
            // Wakeup timer
            // ****************
            // pick the counting source.
            tick = state_r.src ? xtal_edge : slow_edge;
            // zero select stops and clears.
            // A control write restarts the period
            // so a new rate starts from zero.
            if (state_r.dly == 3'h0 || wr_wake)
            begin
                state_nxt.cnt = '0;
            end
            else if (tick)
            begin
                if (state_r.cnt >= term_f(state_r.src, state_r.dly))
                begin
                    state_nxt.cnt = '0;
                    timeout = 1'b1;
                end
                else
                begin
                    state_nxt.cnt = state_r.cnt + CNT_W'(1);
                end
            end

            // set on timeout; an acknowledge write restarts the period,
            // so no timeout falls in its cycle and the flag clears.
            if (timeout)
            begin
                state_nxt.flag = 1'b1;
            end
            else if (ack)
            begin
                state_nxt.flag = 1'b0;
            end

            // Sticky event bit, set beats clear.
            if (timeout)
            begin
                state_nxt.ev_stat[BIT_EV_TIMEOUT] = 1'b1;
            end

            // interrupt follows flag and
            // enable; gates it.
            state_nxt.wirq = state_nxt.flag & state_nxt.ie;
            state_nxt.sirq = |(state_nxt.ev_stat & state_nxt.ev_mask);
        end
    end

    // ********************
    // State register
    // ********************
    // Reset loads constants only.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r <= '0;
            state_r.pin_en <= RST_CLKOUT[BIT_PIN_EN];
            state_r.div_sel <= RST_CLKOUT[2:0];
            state_r.src <= RST_WAKEUP[BIT_SRC];
            state_r.ie <= RST_WAKEUP[BIT_IE];
            state_r.dly <= RST_WAKEUP[2:0];
            state_r.ev_mask <= RST_IRQ_MASK;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ********************
    // Outputs
    // ********************
    // Every output is a flip-flop.
    assign rd_data_o = state_r.rdata;
    assign port_c_bit_two_pin_o = state_r.pin_q;
    assign clock_out_pin_enable_o = state_r.pin_en_q;
    assign wakeup_irq_o = state_r.wirq;
    assign sys_irq_o = state_r.sirq;

endmodule // sysctl_regs

/* File: bench/sysctl_regs_props.sv */
/*
 * Checker for the system control block: register port, clock output, wakeup interrupt.
 * Sees only the top ports; ce_i drops only while the clock pin is off, so ages count every clock.
 */
`timescale 1ns/1ps

module sysctl_regs_props
#(
    parameter logic [11:0] PART_ID = 12'h5A3,
    parameter int CNT_W = 16
)
(
    input logic clock_i,
    input logic resetn_i,
    input logic ce_i,
    input logic [3:0] addr_i,
    input logic [7:0] wr_data_i,
    input logic wr_i,
    input logic rd_i,
    input logic [7:0] rd_data_o,
    input logic slow_osc_i,
    input logic xtal_clk_i,
    input logic port_c_bit_two_pin_o,
    input logic clock_out_pin_enable_o,
    input logic wakeup_irq_o,
    input logic sys_irq_o
);
    import sysctl_pkg::*;
    // ********************
    // Helper logic
    // ********************
    logic [7:0] ck_r; // Last written clock-out control value.
    logic [4:0] ck_age_r; // Cycles since that write, saturating.
    logic [2:0] dly_r; // Last written delay select.
    logic [2:0] wk_age_r; // Cycles since the last wakeup write.
    logic pin_q_r; // Pin one cycle ago.
    logic [3:0] run_r; // Cycles the pin has held its level.
    logic wr_ck;
    logic wr_wk;
    assign wr_ck = ce_i && wr_i && (addr_i == OFS_CLKOUT);
    assign wr_wk = ce_i && wr_i && (addr_i == OFS_WAKEUP);
    // Ages let a setting settle before the pin is judged.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ck_r <= 8'h00;
            ck_age_r <= 5'h00;
            dly_r <= 3'h0;
            wk_age_r <= 3'h0;
            pin_q_r <= 1'b0;
            run_r <= 4'h0;
        end
        else
        begin
            ck_r <= wr_ck ? wr_data_i : ck_r;
            ck_age_r <= wr_ck ? 5'h00 : ck_age_r + {4'h0, ck_age_r != 5'h1F};
            dly_r <= wr_wk ? wr_data_i[2:0] : dly_r;
            wk_age_r <= wr_wk ? 3'h0 : wk_age_r + {2'h0, wk_age_r != 3'h7};
            pin_q_r <= port_c_bit_two_pin_o;
            run_r <= (port_c_bit_two_pin_o != pin_q_r) ? 4'h1 : run_r + {3'h0, run_r != 4'hF};
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // ********************
    // Assertions
    // ********************
    a_pin_en_follow: assert property (wr_ck |-> ##2 clock_out_pin_enable_o == $past(wr_data_i[BIT_PIN_EN], 2))
        else $error("pin enable does not follow its bit");
    a_pin_off_low: assert property ((ck_age_r > 5'h03 && (!ck_r[BIT_PIN_EN] || ck_r[2:0] == 3'h0))
        |-> !port_c_bit_two_pin_o) else $error("clock pin not low");
    a_div_half_period: assert property ((ck_age_r == 5'h1F && ck_r[BIT_PIN_EN] && ck_r[2:0] != 3'h0
        && port_c_bit_two_pin_o != pin_q_r) |-> run_r == {1'b0, ck_r[2:0]}) else $error("clock half period wrong");
    a_rd_idle_zero: assert property (!(ce_i && rd_i) |=> rd_data_o == 8'h00)
        else $error("read data outside read cycle");
    a_part_id_high: assert property ((ce_i && rd_i && addr_i == OFS_PNHIGH) |=> rd_data_o[3:0] == PART_ID[11:8])
        else $error("part number high wrong");
    a_part_id_low: assert property ((ce_i && rd_i && addr_i == OFS_PNLOW) |=> rd_data_o == PART_ID[7:0])
        else $error("part number low wrong");
    a_wake_zero_bits: assert property ((ce_i && rd_i && addr_i == OFS_WAKEUP) |=> rd_data_o[6] == 1'b0
        && rd_data_o[3] == 1'b0) else $error("wakeup zero bits set");
    a_ie_gate: assert property ((wr_wk && !wr_data_i[BIT_IE]) |-> ##2 !wakeup_irq_o [*2])
        else $error("wakeup irq without enable");
    a_ack_clears: assert property ((wr_wk && wr_data_i[BIT_ACK] && wr_data_i[2:0] == 3'h0) |-> ##2 !wakeup_irq_o)
        else $error("acknowledge left irq high");
    a_wake_off: assert property ($rose(wakeup_irq_o) |-> dly_r != 3'h0 || wk_age_r < 3'h4)
        else $error("timeout with timer off");
    a_mask_gate: assert property ((ce_i && wr_i && addr_i == OFS_IRQ_MASK && !wr_data_i[BIT_EV_TIMEOUT])
        |-> ##2 !sys_irq_o) else $error("masked event raised irq");
    a_unmapped_zero: assert property ((ce_i && rd_i && addr_i > OFS_IRQ_MASK) |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
endmodule // sysctl_regs_props

bind sysctl_regs sysctl_regs_props #(.PART_ID(PART_ID), .CNT_W(CNT_W)) u_props (.clock_i(clock_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .slow_osc_i(slow_osc_i), .xtal_clk_i(xtal_clk_i),
    .port_c_bit_two_pin_o(port_c_bit_two_pin_o), .clock_out_pin_enable_o(clock_out_pin_enable_o),
    .wakeup_irq_o(wakeup_irq_o), .sys_irq_o(sys_irq_o));

/* File: bench/tb_top.sv */
/*
 * Self-checking bench for the system control block.
 * Assumes the block alone, driven from here; source pins toggle well below bus/4.
 */
`timescale 1ns/1ps

module tb_top;
    import sysctl_pkg::*;
    localparam logic [11:0] ID = 12'h5A3; // Arbitrary part number.
    localparam int SPER [7] = '{PER_MS_1, PER_MS_2, PER_MS_3, PER_MS_4, PER_MS_5, PER_MS_6, PER_MS_7};
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic slow_osc_i = 1'b0;
    logic xtal_clk_i = 1'b0;
    logic [7:0] rd_data_o;
    logic port_c_bit_two_pin_o;
    logic clock_out_pin_enable_o;
    logic wakeup_irq_o;
    logic sys_irq_o;
    int errors = 0;
    int n_tests = 0;
    int i;
    always #10 clock_i = ~clock_i;
    sysctl_regs #(.PART_ID(ID), .CNT_W(16)) DUT (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .slow_osc_i(slow_osc_i), .xtal_clk_i(xtal_clk_i), .port_c_bit_two_pin_o(port_c_bit_two_pin_o),
        .clock_out_pin_enable_o(clock_out_pin_enable_o), .wakeup_irq_o(wakeup_irq_o), .sys_irq_o(sys_irq_o));
    // ********************
    // Shared tasks
    // ********************
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // One-cycle strobes; the gap cycle keeps a strobe from being set twice in one step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        chk(rd_data_o & m, exp, "read");
    endtask
    // Rising edges on one source pin, three cycles high and three low.
    task automatic pulse(input logic xt, input int n);
        repeat (n)
        begin
            @(posedge clock_i);
            slow_osc_i <= !xt;
            xtal_clk_i <= xt;
            repeat (3) @(posedge clock_i);
            slow_osc_i <= 1'b0;
            xtal_clk_i <= 1'b0;
            repeat (2) @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask
    task automatic pins(input logic [7:0] exp);
        repeat (16)
        begin
            @(negedge clock_i);
            chk({6'h00, clock_out_pin_enable_o, port_c_bit_two_pin_o}, exp, "clock pin");
        end
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        rd(OFS_CLKOUT, 8'h00, 8'hFF);
        rd(OFS_WAKEUP, 8'h00, 8'hFF); // flag clear
        rd(OFS_IRQ_MASK, 8'h00, 8'hFF);
        wr(OFS_PNHIGH, 8'hFF);
        wr(OFS_PNLOW, 8'h00);
        rd(OFS_PNHIGH, {4'h0, ID[11:8]}, 8'h0F); // writes ignored
        rd(OFS_PNLOW, ID[7:0], 8'hFF); // low part
        wr(OFS_CLKOUT, 8'hFF);
        rd(OFS_CLKOUT, 8'h17, 8'hFF);
        wr(OFS_WAKEUP, 8'hFF);
        rd(OFS_WAKEUP, 8'h37, 8'hFF); // zero bits
        wr(OFS_WAKEUP, 8'h00);
        rd(4'h9, 8'h00, 8'hFF);
        $display("t_regs done");
    endtask
    task automatic t_clk();
        int s;
        int h;
        for (s = 1; s < 8; s++)
        begin
            wr(OFS_CLKOUT, 8'h10 | 8'(s));
            repeat (20) @(posedge clock_i);
            @(negedge clock_i);
            for (i = 0; i < 20 && port_c_bit_two_pin_o === port_c_bit_two_pin_o; i++)
            begin
                h = port_c_bit_two_pin_o;
                @(negedge clock_i);
                if (port_c_bit_two_pin_o !== 1'(h))
                    break;
            end
            h = 0;
            for (i = port_c_bit_two_pin_o; h < 20 && port_c_bit_two_pin_o === 1'(i); h++)
                @(negedge clock_i);
            chk(8'(h), 8'(s), "half period"); // divide ratio
            if (h >= 20)
                summarize();
        end
        wr(OFS_CLKOUT, 8'h10);
        repeat (4) @(posedge clock_i);
        pins(8'h02); // held low
        wr(OFS_CLKOUT, 8'h03);
        repeat (4) @(posedge clock_i);
        pins(8'h00); // output off
        $display("t_clk done");
    endtask
    // Strobes taken while the clock enable is low must be dropped.
    task automatic t_ce();
        @(posedge clock_i);
        ce_i <= 1'b0;
        wr(OFS_IRQ_MASK, 8'h01);
        rd(OFS_IRQ_MASK, 8'h00, 8'hFF);
        @(posedge clock_i);
        ce_i <= 1'b1;
        rd(OFS_IRQ_MASK, 8'h00, 8'hFF);
        $display("t_ce done");
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_WAKEUP, 8'h01);
        pulse(1'b0, 8);
        rd(OFS_WAKEUP, 8'h81, 8'hFF); // flag set
        chk({6'h00, wakeup_irq_o, sys_irq_o}, 8'h01, "enable gate"); // enable gates
        wr(OFS_IRQ_MASK, 8'h00);
        rd(OFS_IRQ_STAT, 8'h01, 8'hFF);
        chk({7'h00, sys_irq_o}, 8'h00, "masked");
        wr(OFS_IRQ_STAT, 8'h01);
        rd(OFS_IRQ_STAT, 8'h00, 8'hFF);
        wr(OFS_WAKEUP, 8'h40);
        pulse(1'b0, 40);
        rd(OFS_WAKEUP, 8'h00, 8'hFF); // cleared and off
        $display("t_irq done");
    endtask
    // Period check: no flag one edge early, flag and interrupt on the last edge.
    task automatic t_wake(input logic src, input logic [2:0] dly, input int n);
        logic [7:0] b;
        b = {2'b00, src, 1'b1, 1'b0, dly};
        wr(OFS_WAKEUP, b);
        pulse(!src, 4);
        pulse(src, n - 1);
        rd(OFS_WAKEUP, b, 8'hFF); // not early
        chk({7'h00, wakeup_irq_o}, 8'h00, "early irq");
        pulse(src, 1);
        rd(OFS_WAKEUP, b | 8'h80, 8'hFF); // flag set
        chk({7'h00, wakeup_irq_o}, 8'h01, "irq"); // irq raised
        wr(OFS_WAKEUP, b | 8'h40);
        rd(OFS_WAKEUP, b, 8'hFF); // flag cleared
        chk({7'h00, wakeup_irq_o}, 8'h00, "irq after ack"); // irq dropped
        $display("t_wake %0d %0d done", src, dly);
    endtask
    initial
    begin
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_regs();
        t_clk();
        t_ce();
        t_irq();
        for (i = 1; i < 8; i++)
            t_wake(1'b0, 3'(i), SPER[i - 1] * TICKS_PER_MS); // slow periods
        t_wake(1'b1, 3'h1, XDIV_1); // crystal divide
        t_wake(1'b1, 3'h2, XDIV_2); // crystal divide
        summarize();
    end
endmodule // tb_top
